// ---- logic/device_event_status_reg.sv ----
// Device event flags, enable mask, summary bit and command handling
`timescale 1ns/100ps
`default_nettype none
module device_event_status_reg import dev_event_pkg::*; (
  input  wire logic           i_clock,             // 25 MHz system clock
  input  wire logic           i_rst_b,             // Sync reset, active low
  input  wire command_s       i_command,           // Decoded command, valid one cycle
  input  wire settings_s      i_settings,          // Data for settings write
  input  wire buffer_events_s i_buffer,            // Buffer events, same clock
  input  wire logic           i_stop_key,          // Front stop key, async, high pressed
  input  wire logic           i_handler_stop_b,    // Handler stop pin, async, low active
  input  wire logic           i_interlock_b,       // Interlock pin, async, low active
  output response_s           o_response,          // Query answer
  output logic                o_device_summary_bit,// Summary into the status byte
  output logic                o_clear_status,      // Clears other status registers
  output logic [7:0]          o_event_mask,        // Current enable mask
  output logic [7:0]          o_event_flags,       // Current flag register
  output logic                o_start_inhibit,     // Starting is blocked
  output settings_s           o_settings           // Measurement settings
);

  // Synchronised pin levels
  logic [2:0] pin_raw;
  logic [2:0] pin_level;
  logic       stop_key;
  logic       handler_stop;
  logic       interlock;

  assign pin_raw = {i_stop_key, ~i_handler_stop_b, ~i_interlock_b};

  pin_sync #(
    .WIDTH (3)
  ) u_pin_sync (
    .i_clock (i_clock),
    .i_rst_b (i_rst_b),
    .i_async (pin_raw),
    .o_sync  (pin_level)
  );

  assign stop_key     = pin_level[2];
  assign handler_stop = pin_level[1];
  assign interlock    = pin_level[0];

  // A pin change reaches the flags three edges later: two sync stages and
  // the flag register. The low-active pins are inverted ahead of the
  // synchroniser, so every level here is high when active and a history
  // reset low can never show a false edge right after reset.
  logic [2:0] pin_prev;
  logic [2:0] next_pin_prev;
  logic       full_prev;
  logic       next_full_prev;

  // History follows the synchronised levels one cycle late
  always_comb begin
    next_pin_prev  = pin_level;
    next_full_prev = i_buffer.full;
  end

  // Edge history registers
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      pin_prev  <= '0;
      full_prev <= 1'b0;
    end else begin
      pin_prev  <= next_pin_prev;
      full_prev <= next_full_prev;
    end
  end

  // True when a valid command of the given kind sits on the port;
  // a stale code with valid low must never act
  function automatic logic cmd_is(
    input command_s cmd_in,  // Command port value
    input cmd_e     kind     // Kind to look for
  );
    return cmd_in.valid && (cmd_in.cmd == kind);
  endfunction

  // Command decode
  logic       cmd_mask_set;
  logic       cmd_mask_query;
  logic       cmd_event_query;
  logic       cmd_clear;
  logic       cmd_reset;
  logic       cmd_write;

  // One strobe per command kind, at most one per cycle; CMD_NONE decodes to nothing
  always_comb begin
    cmd_mask_set    = cmd_is(i_command, CMD_MASK_SET);
    cmd_mask_query  = cmd_is(i_command, CMD_MASK_QUERY);
    cmd_event_query = cmd_is(i_command, CMD_EVENT_QUERY);
    cmd_clear       = cmd_is(i_command, CMD_CLEAR_STATUS);
    cmd_reset       = cmd_is(i_command, CMD_RESET_MSG);
    cmd_write       = cmd_is(i_command, CMD_SETTINGS_WRITE);
  end

  // Requests that empty flags, shared by the flag groups
  logic       read_clear_req;
  logic       full_clear_req;

  // A read empties only read-clearing flags; clear-status also drops full
  always_comb begin
    read_clear_req = cmd_event_query || cmd_clear;
    full_clear_req = cmd_clear || i_buffer.empty;
  end

  // Event pulses from this cycle
  logic stop_event;
  logic full_event;
  logic overflow_event;

  // Stop key rises, handler stop and interlock fall at their pins
  always_comb begin
    stop_event = (stop_key && !pin_prev[2])
               || (handler_stop && !pin_prev[1])
               || (interlock && !pin_prev[0]);
    full_event     = i_buffer.full && !full_prev;
    overflow_event = i_buffer.data_lost;
  end

  // Each flag is a register of its own. In every group the event that
  // sets a flag wins over a read, a clear-status or a drained buffer in
  // the same cycle: the answer already carries the old value, so a dropped
  // event would never reach the host.
  logic [7:0] flags;
  logic       buffer_overflow_flag;
  logic       buffer_full_flag;
  logic       stop_event_flag;
  logic       interlock_state_flag;
  logic       next_buffer_overflow_flag;
  logic       next_buffer_full_flag;
  logic       next_stop_event_flag;
  logic       next_interlock_state_flag;

  // Overflow flag, emptied by a read or clear-status
  always_comb begin
    next_buffer_overflow_flag = buffer_overflow_flag;
    if (read_clear_req) begin
      next_buffer_overflow_flag = 1'b0;
    end
    // A sample lost in the read cycle sets it again for the next read
    if (overflow_event) begin
      next_buffer_overflow_flag = 1'b1;
    end
  end

  // Overflow flag register
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      buffer_overflow_flag <= FLAGS_RESET[BIT_BUF_OVERFLOW];
    end else begin
      buffer_overflow_flag <= next_buffer_overflow_flag;
    end
  end

  // Full flag, held through reads until the buffer drains
  always_comb begin
    next_buffer_full_flag = buffer_full_flag;
    // Once dropped by clear-status it sets again only on the next full rise
    if (full_clear_req) begin
      next_buffer_full_flag = 1'b0;
    end
    if (full_event) begin
      next_buffer_full_flag = 1'b1;
    end
  end

  // Full flag register
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      buffer_full_flag <= FLAGS_RESET[BIT_BUF_FULL];
    end else begin
      buffer_full_flag <= next_buffer_full_flag;
    end
  end

  // Stop flag; several sources in one cycle still set it once
  always_comb begin
    next_stop_event_flag = stop_event_flag;
    if (read_clear_req) begin
      next_stop_event_flag = 1'b0;
    end
    if (stop_event) begin
      next_stop_event_flag = 1'b1;
    end
  end

  // Stop flag register
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      stop_event_flag <= FLAGS_RESET[BIT_STOP_EVENT];
    end else begin
      stop_event_flag <= next_stop_event_flag;
    end
  end

  // Interlock flag follows the level, so neither a read nor clear-status
  // can hide an interlock that still blocks starting
  always_comb begin
    next_interlock_state_flag = interlock;
  end

  // Interlock flag register
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      interlock_state_flag <= FLAGS_RESET[BIT_INTERLOCK];
    end else begin
      interlock_state_flag <= next_interlock_state_flag;
    end
  end

  // Pack the flags into the register byte; unused and reserved bits read zero
  function automatic logic [7:0] pack_flags(
    input logic overflow,  // Buffer overflow
    input logic full,      // Buffer full
    input logic stop,      // Stop event
    input logic locked     // Interlock state
  );
    logic [7:0] value;
    value                   = 8'h00;
    value[BIT_BUF_OVERFLOW] = overflow;
    value[BIT_BUF_FULL]     = full;
    value[BIT_STOP_EVENT]   = stop;
    value[BIT_INTERLOCK]    = locked;
    return value & FLAG_USED_MASK;
  endfunction

  // Flag byte seen by the queries, the summary and the outputs
  assign flags = pack_flags(buffer_overflow_flag, buffer_full_flag,
                            stop_event_flag, interlock_state_flag);

  // Event enable mask; zero keeps the summary low whatever the flags hold
  logic [7:0] mask;
  logic [7:0] next_mask;

  // Only the mask-set command writes it; queries and clear-status leave it
  always_comb begin
    next_mask = mask;
    if (cmd_mask_set) begin
      next_mask = i_command.data;
    end
  end

  // Mask register
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      mask <= MASK_RESET;
    end else begin
      mask <= next_mask;
    end
  end

  // Summary of the enabled flags; a masked-off flag is still kept and read
  function automatic logic summary_of(
    input logic [7:0] flag_byte,  // Flag register
    input logic [7:0] enable      // Enable mask
  );
    return |(flag_byte & enable);
  endfunction

  // Query answers and clear pulse, registered one cycle after the command
  response_s next_response;
  logic      next_clear_status;

  always_comb begin
    next_response.valid = cmd_mask_query || cmd_event_query;
    next_response.data  = 8'h00;
    if (cmd_mask_query) begin
      next_response.data = mask;
    end else if (cmd_event_query) begin
      next_response.data = flags & FLAG_USED_MASK;
    end
    next_clear_status = cmd_clear;
  end

  // Answer and clear pulse registers
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      o_response     <= '0;
      o_clear_status <= 1'b0;
    end else begin
      o_response     <= next_response;
      o_clear_status <= next_clear_status;
    end
  end

  // Summary follows flags and mask with no register, so a mask write
  // shows on the status byte in the cycle after the command
  assign o_device_summary_bit = summary_of(flags, mask);
  assign o_event_mask         = mask;
  assign o_event_flags        = flags;
  assign o_start_inhibit      = interlock_state_flag;

  // Settings keep their own store; only the reset message and a write reach it
  settings_store u_settings_store (
    .i_clock    (i_clock),
    .i_rst_b    (i_rst_b),
    .i_defaults (cmd_reset),
    .i_write    (cmd_write),
    .i_settings (i_settings),
    .o_settings (o_settings)
  );

endmodule
`default_nettype wire

// ---- logic/dev_event_pkg.sv ----
// Constants, types and command codes of the device event status block
package dev_event_pkg;

  // Flag register layout
  localparam int FLAG_WIDTH        = 8;
  localparam int BIT_BUF_OVERFLOW  = 5;
  localparam int BIT_BUF_FULL      = 4;
  localparam int BIT_STOP_EVENT    = 3;
  localparam int BIT_INTERLOCK     = 2;
  localparam logic [7:0] FLAG_USED_MASK = 8'h3C;
  localparam logic [7:0] MASK_RESET     = 8'h00;
  localparam logic [7:0] FLAGS_RESET    = 8'h00;

  // Reset message values, each in its own unit
  localparam logic [3:0]  TEST_VOLTAGE_DV   = 4'h1;    // 0.1 V in 100 mV steps
  localparam logic [8:0]  INTEGRATION_MS    = 9'h12C;  // 300 ms
  localparam logic [13:0] TRIGGER_DELAY_MS  = 14'h0000;
  localparam logic [3:0]  SEQ_PROGRAM_NUM   = 4'h0;
  localparam logic [2:0]  DISPLAY_DIGITS    = 3'h5;
  localparam logic [5:0]  CURRENT_LIMIT_MA  = 6'h05;   // 5 mA
  localparam logic [7:0]  OPEN_CORR_DPF     = 8'h05;   // 0.5 pF in 0.1 pF steps

  typedef enum logic [1:0] {MEAS_RESISTANCE, MEAS_CURRENT, MEAS_RESISTIVITY} measure_e;
  typedef enum logic [0:0] {TRIG_INTERNAL, TRIG_EXTERNAL} trigger_e;
  typedef enum logic [0:0] {DISP_EXPONENT, DISP_FIXED} display_e;

  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_MASK_SET,
    CMD_MASK_QUERY,
    CMD_EVENT_QUERY,
    CMD_CLEAR_STATUS,
    CMD_RESET_MSG,
    CMD_SETTINGS_WRITE
  } cmd_e;

  // Settings that the reset message restores
  typedef struct packed {
    measure_e    measure_function;
    trigger_e    trigger_source;
    logic [3:0]  test_voltage;
    logic [8:0]  integration_time;
    logic        averaging;
    logic        auto_range;
    logic [13:0] trigger_delay;
    logic        sequence_on;
    logic [3:0]  sequence_program;
    display_e    display_mode;
    logic [2:0]  display_digits;
    logic        deviation_display;
    logic        auto_voltage_check;
    logic        auto_contact_check;
    logic [5:0]  current_limit;
    logic        charge_limit;
    logic        filter_on;
    logic [7:0]  open_correction;
  } settings_s;

  localparam settings_s SETTINGS_DEFAULT = '{
    measure_function:   MEAS_RESISTANCE,
    trigger_source:     TRIG_INTERNAL,
    test_voltage:       TEST_VOLTAGE_DV,
    integration_time:   INTEGRATION_MS,
    averaging:          1'b1,
    auto_range:         1'b1,
    trigger_delay:      TRIGGER_DELAY_MS,
    sequence_on:        1'b0,
    sequence_program:   SEQ_PROGRAM_NUM,
    display_mode:       DISP_EXPONENT,
    display_digits:     DISPLAY_DIGITS,
    deviation_display:  1'b0,
    auto_voltage_check: 1'b0,
    auto_contact_check: 1'b0,
    current_limit:      CURRENT_LIMIT_MA,
    charge_limit:       1'b0,
    filter_on:          1'b1,
    open_correction:    OPEN_CORR_DPF
  };

  // Decoded command from the message parser
  typedef struct packed {
    logic       valid;
    cmd_e       cmd;
    logic [7:0] data;
  } command_s;

  // Answer to a query
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } response_s;

  // Same-clock measurement buffer events
  typedef struct packed {
    logic data_lost;
    logic full;
    logic empty;
  } buffer_events_s;

endpackage

// ---- logic/pin_sync.sv ----
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/100ps
`default_nettype none
module pin_sync import dev_event_pkg::*; #(
  parameter int WIDTH = 3
) (
  input  wire logic             i_clock,  // System clock
  input  wire logic             i_rst_b,  // Sync reset, active low
  input  wire logic [WIDTH-1:0] i_async,  // Raw pin levels
  output logic      [WIDTH-1:0] o_sync    // Levels safe to use
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_sync;

  // First stage feeds only the second stage
  always_comb begin
    next_meta = i_async;
    next_sync = meta;
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      meta   <= '0;
      o_sync <= '0;
    end else begin
      meta   <= next_meta;
      o_sync <= next_sync;
    end
  end

endmodule
`default_nettype wire

// ---- logic/settings_store.sv ----
// Measurement and display settings restored by the reset message
`timescale 1ns/100ps
`default_nettype none
module settings_store import dev_event_pkg::*; (
  input  wire logic      i_clock,     // System clock
  input  wire logic      i_rst_b,     // Sync reset, active low
  input  wire logic      i_defaults,  // Reset message pulse
  input  wire logic      i_write,     // Settings write pulse
  input  wire settings_s i_settings,  // Value to write
  output settings_s      o_settings   // Current settings
);

  settings_s next_settings;

  // Reset message wins over a write in the same cycle
  always_comb begin
    next_settings = o_settings;
    if (i_defaults) begin
      next_settings = SETTINGS_DEFAULT;
    end else if (i_write) begin
      next_settings = i_settings;
    end
  end

  // Programs, limits, buffer and setups live elsewhere and are never touched here
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      o_settings <= SETTINGS_DEFAULT;
    end else begin
      o_settings <= next_settings;
    end
  end

endmodule
`default_nettype wire

// ---- verif/dev_event_chk.sv ----
// Port assertions for the device event status block
`timescale 1ns/100ps
`default_nettype none
module dev_event_chk import dev_event_pkg::*; (
  input wire logic           i_clock,              // Clock
  input wire logic           i_rst_b,              // Reset, low
  input wire command_s       i_command,            // Command
  input wire buffer_events_s i_buffer,             // Buffer events
  input wire response_s      o_response,           // Answer
  input wire logic           o_device_summary_bit, // Summary
  input wire logic           o_clear_status,       // Clear pulse
  input wire logic [7:0]     o_event_mask,         // Mask
  input wire logic [7:0]     o_event_flags,        // Flags
  input wire logic           o_start_inhibit,      // Inhibit
  input wire settings_s      o_settings            // Settings
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  // Summary and flag layout
  property p_summary; o_device_summary_bit == |(o_event_flags & o_event_mask); endproperty
  a_summary: assert property (p_summary) else $error("summary wrong");
  property p_unused; o_event_flags[7:6] == 2'h0 && o_event_flags[1:0] == 2'h0; endproperty
  a_unused: assert property (p_unused) else $error("unused bit set");
  property p_inhibit; o_start_inhibit == o_event_flags[2]; endproperty
  a_inhibit: assert property (p_inhibit) else $error("inhibit differs");
  // Commands, answers one cycle after taking
  property p_mask_set;
    i_command.valid && i_command.cmd == CMD_MASK_SET |=> o_event_mask == $past(i_command.data);
  endproperty
  a_mask_set: assert property (p_mask_set) else $error("mask not stored");
  property p_mask_qry; i_command.valid && i_command.cmd == CMD_MASK_QUERY |=>
    o_response.valid && o_response.data == o_event_mask && $stable(o_event_mask); endproperty
  a_mask_qry: assert property (p_mask_qry) else $error("mask answer wrong");
  property p_evt_qry; i_command.valid && i_command.cmd == CMD_EVENT_QUERY |=>
    o_response.valid && o_response.data == $past(o_event_flags); endproperty
  a_evt_qry: assert property (p_evt_qry) else $error("flag answer wrong");
  property p_clear; i_command.valid && i_command.cmd == CMD_CLEAR_STATUS |=> o_clear_status;
  endproperty
  a_clear: assert property (p_clear) else $error("no clear pulse");
  property p_defaults; i_command.valid && i_command.cmd == CMD_RESET_MSG |=>
    o_settings == SETTINGS_DEFAULT; endproperty
  a_defaults: assert property (p_defaults) else $error("defaults not loaded");
  // Buffer flags; a set wins over a clear in the same cycle
  property p_lost; i_buffer.data_lost |=> o_event_flags[5]; endproperty
  a_lost: assert property (p_lost) else $error("overflow flag missed");
  property p_rd_clr; i_command.valid && i_command.cmd == CMD_EVENT_QUERY && !i_buffer.data_lost
    |=> !o_event_flags[5]; endproperty
  a_rd_clr: assert property (p_rd_clr) else $error("overflow not cleared");
  property p_full; $rose(i_buffer.full) |=> o_event_flags[4]; endproperty
  a_full: assert property (p_full) else $error("full flag missed");
  property p_empty; i_buffer.empty && !i_buffer.full |=> !o_event_flags[4]; endproperty
  a_empty: assert property (p_empty) else $error("full flag kept");
endmodule
`default_nettype wire

// ---- verif/host_model.sv ----
// Host controller model issuing decoded commands
`timescale 1ns/100ps
`default_nettype none
module host_model import dev_event_pkg::*; (
  input  wire logic      i_clock,    // System clock
  input  wire response_s i_response, // Answer from device
  output var command_s   o_command   // Command to device
);
  // Idle data is inverted so a stale byte is never mistaken for a new one
  initial o_command = '0;
  // Held up to the taking edge, answer read in the following cycle
  task automatic send(input cmd_e cmd, input logic [7:0] data, output response_s rsp);
    @(posedge i_clock) o_command <= '{valid: 1'b1, cmd: cmd, data: data};
    @(posedge i_clock) o_command <= '{valid: 1'b0, cmd: CMD_NONE, data: ~data};
    #1 rsp = i_response;
  endtask
endmodule
`default_nettype wire

// ---- verif/device_event_status_reg_bench.sv ----
// Self-checking bench of the device event status block
`timescale 1ns/100ps
`default_nettype none
module device_event_status_reg_bench import dev_event_pkg::*;;
  logic           clock, rst_b, stop_key, hstop_b, ilock_b, summary, clear_status, inhibit;
  settings_s      settings, cur, s;
  buffer_events_s buffer;
  command_s       command;
  response_s      response, r;
  logic [7:0]     mask, flags, m;
  logic [63:0]    rnd;
  int             n_fail = 0, tests_run = 0, cycles = 0, seed = 67824, k;
  // Clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  host_model host (.i_clock(clock), .i_response(response), .o_command(command));
  device_event_status_reg u_device_event_status_reg (
    .i_clock(clock), .i_rst_b(rst_b), .i_command(command), .i_settings(settings),
    .i_buffer(buffer), .i_stop_key(stop_key), .i_handler_stop_b(hstop_b),
    .i_interlock_b(ilock_b), .o_response(response), .o_device_summary_bit(summary),
    .o_clear_status(clear_status), .o_event_mask(mask), .o_event_flags(flags),
    .o_start_inhibit(inhibit), .o_settings(cur));
  // Comparisons
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_set(input settings_s got, input settings_s exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Pins cross two sync stages before the flag moves
  task automatic wait_pins;
    repeat (3) @(posedge clock);
    #1;
  endtask
  function automatic logic [7:0] stop_flags(input int src);
    return (src == 2) ? 8'h0C : 8'h08;
  endfunction
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Hang guard, the whole run needs well under this
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      n_fail++;
      print_verdict;
    end
  end
  // Main sequence
  initial begin
    rst_b = 1'b0;
    settings = '0;
    buffer = '{1'b0, 1'b0, 1'b1};
    stop_key = 1'b0;
    hstop_b = 1'b1;
    ilock_b = 1'b1;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    #1 chk(flags, FLAGS_RESET);
    chk(mask, MASK_RESET);
    chk_set(cur, SETTINGS_DEFAULT);
    for (k = 0; k < 10; k++) begin
      m = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : 8'($random(seed));
      host.send(CMD_MASK_SET, m, r);
      chk(mask, m);
      host.send(CMD_MASK_QUERY, ~m, r);
      chk(r.data, m);
      chk({7'h00, r.valid}, 8'h01);
    end
    $display("test mask done");
    host.send(CMD_MASK_SET, 8'h20, r);
    @(posedge clock) buffer.data_lost <= 1'b1;
    @(posedge clock) buffer.data_lost <= 1'b0;
    #1 chk(flags, 8'h20);
    chk({7'h00, summary}, 8'h01);
    host.send(CMD_EVENT_QUERY, 8'h00, r);
    chk(r.data, 8'h20);
    chk(flags, 8'h00);
    chk({7'h00, summary}, 8'h00);
    $display("test overflow done");
    @(posedge clock) buffer <= '{1'b0, 1'b1, 1'b0};
    @(posedge clock) #1 chk(flags, 8'h10);
    host.send(CMD_EVENT_QUERY, 8'h00, r);
    chk(r.data, 8'h10);
    chk(flags, 8'h10);
    @(posedge clock) buffer <= '{1'b0, 1'b0, 1'b1};
    @(posedge clock) #1 chk(flags, 8'h00);
    $display("test full done");
    for (k = 0; k < 3; k++) begin
      @(posedge clock) begin
        stop_key <= (k == 0);
        hstop_b <= (k != 1);
        ilock_b <= (k != 2);
      end
      wait_pins;
      chk(flags, stop_flags(k));
      chk({7'h00, inhibit}, {7'h00, k == 2});
      @(posedge clock) begin
        stop_key <= 1'b0;
        hstop_b <= 1'b1;
        ilock_b <= 1'b1;
      end
      wait_pins;
      host.send(CMD_EVENT_QUERY, 8'h00, r);
      chk(r.data, stop_flags(k) & 8'h08);
      chk(flags, 8'h00);
    end
    $display("test stop done");
    @(posedge clock) buffer <= '{1'b1, 1'b1, 1'b0};
    @(posedge clock) buffer <= '{1'b0, 1'b1, 1'b0};
    #1 chk(flags, 8'h30);
    host.send(CMD_CLEAR_STATUS, 8'h00, r);
    chk({7'h00, clear_status}, 8'h01);
    chk(flags, 8'h00);
    @(posedge clock) buffer <= '{1'b0, 1'b0, 1'b1};
    $display("test clear done");
    rnd = {$random(seed), $random(seed)};
    s = rnd[59:0];
    s.measure_function = MEAS_CURRENT;
    @(posedge clock) settings <= s;
    host.send(CMD_SETTINGS_WRITE, 8'h00, r);
    chk_set(cur, s);
    host.send(CMD_RESET_MSG, 8'h00, r);
    chk_set(cur, SETTINGS_DEFAULT);
    chk(mask, 8'h20);
    $display("test settings done");
    print_verdict;
  end
endmodule
bind device_event_status_reg dev_event_chk u_dev_event_chk (
  .i_clock(i_clock), .i_rst_b(i_rst_b), .i_command(i_command), .i_buffer(i_buffer),
  .o_response(o_response), .o_device_summary_bit(o_device_summary_bit),
  .o_clear_status(o_clear_status), .o_event_mask(o_event_mask),
  .o_event_flags(o_event_flags), .o_start_inhibit(o_start_inhibit), .o_settings(o_settings));
`default_nettype wire
